// ==== rtl/asf_pkg.sv ====
package asf_pkg;

	// ----------------------------------------------------------------
	// Wishbone register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_FLAGS = 4'h0;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

	// ----------------------------------------------------------------
	// Flag register layout
	// ----------------------------------------------------------------
	localparam int BIT_CARRY = 0;
	localparam int BIT_NIBBLE = 1;
	localparam int BIT_ZERO = 2;
	localparam int BIT_HALT = 3;
	localparam int BIT_WDOG = 4;
	localparam logic [7:0] FLAGS_RESET = 8'h18;
	localparam logic [7:0] FLAGS_IMPL = 8'h1f;

	// ----------------------------------------------------------------
	// Event status layout
	// ----------------------------------------------------------------
	localparam int EV_TIMEOUT = 0;
	localparam int EV_HALT = 1;
	localparam int EV_WDCLR = 2;
	localparam int EV_ZERO = 3;
	localparam int EV_CARRY = 4;
	localparam int EV_NUM = 5;
	localparam logic [4:0] EV_NONE = 5'h00;

	// ----------------------------------------------------------------
	// ALU operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ASF_OP_NONE,
		ASF_OP_ADD,
		ASF_OP_SUB,
		ASF_OP_AND,
		ASF_OP_OR,
		ASF_OP_XOR,
		ASF_OP_CLEAR,
		ASF_OP_ROTL,
		ASF_OP_ROTR,
		ASF_OP_MOVE,
		ASF_OP_SWAP,
		ASF_OP_BSET,
		ASF_OP_BCLR,
		ASF_OP_PASS
	} asf_op_t;

	typedef struct packed {
		logic valid;
		asf_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic [2:0] bit_sel;
		logic dest_flags;
	} asf_instr_t;

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] result;
		logic result_valid;
		logic [EV_NUM-1:0] ev_status;
		logic [EV_NUM-1:0] ev_mask;
		logic irq;
		logic ack;
		logic [31:0] rdata;
	} asf_state_t;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage : asf_pkg

// ==== rtl/asf_flags.sv ====
`timescale 1ns/100ps
`default_nettype none

module asf_flags
	import asf_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire asf_instr_t INSTR_IN,
	input wire logic WDOG_TIMEOUT_IN,
	input wire logic WDOG_CLEAR_IN,
	input wire logic HALT_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [3:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	output logic [7:0] FLAGS_OUT,
	output logic [7:0] RESULT_OUT,
	output logic RESULT_VALID_OUT,
	output logic IRQ_OUT
);

	// ----------------------------------------------------------------
	// State and the table of what each operation touches
	// ----------------------------------------------------------------
	asf_state_t state;
	asf_state_t next_state;

	typedef struct packed {
		logic zero;
		logic nibble;
		logic carry;
		logic writes;
	} asf_effect_t;

	// ----------------------------------------------------------------
	// Flags each operation drives
	// ----------------------------------------------------------------
	// A flag named here blocks a plain write to all three low bits
	function automatic asf_effect_t op_effect(input asf_op_t op);
		asf_effect_t fx;
		fx = '0;
		fx.writes = 1'b1;
		unique case (op)
			ASF_OP_ADD:
			begin
				fx.zero = 1'b1;
				fx.nibble = 1'b1;
				fx.carry = 1'b1;
			end
			ASF_OP_SUB:
			begin
				fx.zero = 1'b1;
				fx.nibble = 1'b1;
				fx.carry = 1'b1;
			end
			ASF_OP_AND:
				fx.zero = 1'b1;
			ASF_OP_OR:
				fx.zero = 1'b1;
			ASF_OP_XOR:
				fx.zero = 1'b1;
			ASF_OP_CLEAR:
				fx.zero = 1'b1;
			ASF_OP_ROTL:
				fx.carry = 1'b1;
			ASF_OP_ROTR:
				fx.carry = 1'b1;
			ASF_OP_MOVE:
				fx.writes = 1'b1;
			ASF_OP_SWAP:
				fx.writes = 1'b1;
			ASF_OP_BSET:
				fx.writes = 1'b1;
			ASF_OP_BCLR:
				fx.writes = 1'b1;
			ASF_OP_PASS:
				fx.writes = 1'b1;
			ASF_OP_NONE:
				fx.writes = 1'b0;
			default:
				fx.writes = 1'b0;
		endcase
		return fx;
	endfunction : op_effect

	// ----------------------------------------------------------------
	// Carry chains for add and subtract
	// ----------------------------------------------------------------
	// Inverted operand plus carry in, so carries read as no-borrow
	function automatic logic [8:0] byte_sum(input logic [7:0] a,
		input logic [7:0] b, input logic sub);
		logic [7:0] opb;
		logic [8:0] cin;
		opb = sub ? ~b : b;
		cin = {8'h00, sub};
		return {1'b0, a} + {1'b0, opb} + cin;
	endfunction : byte_sum

	function automatic logic [4:0] nibble_sum(input logic [3:0] a,
		input logic [3:0] b, input logic sub);
		logic [3:0] opb;
		logic [4:0] cin;
		opb = sub ? ~b : b;
		cin = {4'h0, sub};
		return {1'b0, a} + {1'b0, opb} + cin;
	endfunction : nibble_sum

	// ----------------------------------------------------------------
	// Bus read mux
	// ----------------------------------------------------------------
	// Unmapped offsets read as zero
	function automatic logic [31:0] read_word(input logic [3:0] adr,
		input logic [7:0] flags, input logic [EV_NUM-1:0] status,
		input logic [EV_NUM-1:0] mask);
		logic [31:0] word;
		word = WORD_ZERO;
		unique case (adr)
			ADDR_FLAGS:
				word[7:0] = flags;
			ADDR_IRQ_STATUS:
				word[EV_NUM-1:0] = status;
			ADDR_IRQ_MASK:
				word[EV_NUM-1:0] = mask;
			default:
				word = WORD_ZERO;
		endcase
		return word;
	endfunction : read_word

	// ----------------------------------------------------------------
	// Event status
	// ----------------------------------------------------------------
	// A new event wins over a write-one clear in the same cycle
	function automatic logic [EV_NUM-1:0] status_update(
		input logic [EV_NUM-1:0] status, input logic clr_en,
		input logic [EV_NUM-1:0] clr, input logic [EV_NUM-1:0] set);
		logic [EV_NUM-1:0] kept;
		kept = status;
		if (clr_en)
			kept = status & ~clr;
		return kept | set;
	endfunction : status_update

	// ----------------------------------------------------------------
	// Datapath and flag update
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [8:0] sum;
		logic [4:0] nsum;
		logic [7:0] res;
		logic [7:0] fl;
		logic is_sub;
		logic wr;
		logic [EV_NUM-1:0] ev;
		logic bus_req;
		logic rd_req;
		logic wr_req;
		asf_effect_t fx;
		sum = 9'h000;
		nsum = 5'h00;
		res = BYTE_ZERO;
		is_sub = 1'b0;
		wr = 1'b0;
		ev = EV_NONE;
		bus_req = 1'b0;
		rd_req = 1'b0;
		wr_req = 1'b0;
		fx = op_effect(INSTR_IN.op);
		fl = state.flags;
		next_state = state;
		next_state.result_valid = 1'b0;
		next_state.ack = 1'b0;

		// ------------------------------------------------------------
		// Adder shared by add and subtract
		// ------------------------------------------------------------
		is_sub = (INSTR_IN.op == ASF_OP_SUB);
		sum = byte_sum(INSTR_IN.a, INSTR_IN.b, is_sub);
		nsum = nibble_sum(INSTR_IN.a[3:0], INSTR_IN.b[3:0], is_sub);
		wr = INSTR_IN.valid && fx.writes;

		// ------------------------------------------------------------
		// Result byte
		// ------------------------------------------------------------
		unique case (INSTR_IN.op)
			ASF_OP_ADD, ASF_OP_SUB:
				res = sum[7:0];
			ASF_OP_AND:
				res = INSTR_IN.a & INSTR_IN.b;
			ASF_OP_OR:
				res = INSTR_IN.a | INSTR_IN.b;
			ASF_OP_XOR:
				res = INSTR_IN.a ^ INSTR_IN.b;
			ASF_OP_CLEAR:
				res = BYTE_ZERO;
			ASF_OP_ROTL:
				res = {INSTR_IN.a[6:0], state.flags[BIT_CARRY]};
			ASF_OP_ROTR:
				res = {state.flags[BIT_CARRY], INSTR_IN.a[7:1]};
			ASF_OP_SWAP:
				res = {INSTR_IN.a[3:0], INSTR_IN.a[7:4]};
			ASF_OP_BSET:
				res = INSTR_IN.a | (8'h01 << INSTR_IN.bit_sel);
			ASF_OP_BCLR:
				res = INSTR_IN.a & ~(8'h01 << INSTR_IN.bit_sel);
			ASF_OP_MOVE, ASF_OP_PASS:
				res = INSTR_IN.a;
			ASF_OP_NONE:
				res = BYTE_ZERO;
			default:
				res = BYTE_ZERO;
		endcase

		// ------------------------------------------------------------
		// Arithmetic flags
		// ------------------------------------------------------------
		if (wr)
		begin
			// Plain write only when the instruction drives no flag
			if (INSTR_IN.dest_flags && !fx.zero && !fx.nibble
				&& !fx.carry)
			begin
				fl[BIT_ZERO] = res[BIT_ZERO];
				fl[BIT_NIBBLE] = res[BIT_NIBBLE];
				fl[BIT_CARRY] = res[BIT_CARRY];
			end
			if (fx.zero)
				fl[BIT_ZERO] = (res == BYTE_ZERO);
			if (fx.nibble)
				fl[BIT_NIBBLE] = nsum[4];
			if (fx.carry && INSTR_IN.op == ASF_OP_ROTL)
				fl[BIT_CARRY] = INSTR_IN.a[7];
			else if (fx.carry && INSTR_IN.op == ASF_OP_ROTR)
				fl[BIT_CARRY] = INSTR_IN.a[0];
			else if (fx.carry)
				fl[BIT_CARRY] = sum[8];
			next_state.result = res;
			next_state.result_valid = 1'b1;
		end

		// ------------------------------------------------------------
		// Reset-cause bits
		// ------------------------------------------------------------
		// Cause bits move only on hardware events
		if (WDOG_TIMEOUT_IN)
		begin
			fl[BIT_WDOG] = 1'b0;
			ev[EV_TIMEOUT] = 1'b1;
		end
		else if (WDOG_CLEAR_IN)
		begin
			fl[BIT_WDOG] = 1'b1;
			fl[BIT_HALT] = 1'b1;
			ev[EV_WDCLR] = 1'b1;
		end
		else if (HALT_IN)
		begin
			fl[BIT_WDOG] = 1'b1;
			fl[BIT_HALT] = 1'b0;
			ev[EV_HALT] = 1'b1;
		end
		if (wr && fx.zero && fl[BIT_ZERO])
			ev[EV_ZERO] = 1'b1;
		if (wr && fx.nibble && fl[BIT_CARRY])
			ev[EV_CARRY] = 1'b1;
		next_state.flags = fl & FLAGS_IMPL;

		// ------------------------------------------------------------
		// Wishbone slave, one wait state, write-one-to-clear status
		// ------------------------------------------------------------
		// Ack high in the answer cycle keeps a held strobe from
		// being taken twice
		bus_req = WB_CYC_IN && WB_STB_IN && !state.ack;
		wr_req = bus_req && WB_WE_IN && WB_SEL_IN[0];
		rd_req = bus_req && !WB_WE_IN;
		next_state.ack = bus_req;
		if (rd_req)
			next_state.rdata = read_word(WB_ADR_IN, state.flags,
				state.ev_status, state.ev_mask);
		else
			next_state.rdata = WORD_ZERO;
		if (wr_req && WB_ADR_IN == ADDR_IRQ_MASK)
			next_state.ev_mask = WB_DAT_IN[EV_NUM-1:0];
		// Set wins over a same-cycle clear
		next_state.ev_status = status_update(state.ev_status,
			wr_req && WB_ADR_IN == ADDR_IRQ_STATUS,
			WB_DAT_IN[EV_NUM-1:0], ev);
		next_state.irq = |(next_state.ev_status & next_state.ev_mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!NRST_IN)
		begin
			// Cause bits come up set, as after power-up
			state.flags <= FLAGS_RESET;
			state.result <= BYTE_ZERO;
			state.result_valid <= 1'b0;
			state.ev_status <= EV_NONE;
			state.ev_mask <= EV_NONE;
			state.irq <= 1'b0;
			state.ack <= 1'b0;
			state.rdata <= WORD_ZERO;
		end
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// Outputs, straight from the state flops
	// ----------------------------------------------------------------
	assign FLAGS_OUT = state.flags;
	assign RESULT_OUT = state.result;
	assign RESULT_VALID_OUT = state.result_valid;
	assign IRQ_OUT = state.irq;
	assign WB_ACK_OUT = state.ack;
	assign WB_DAT_OUT = state.rdata;

endmodule : asf_flags

`default_nettype wire

// ==== bench/asf_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----
// Decoder and watchdog stand-in
// ----
module asf_core_model
	import asf_pkg::*;
(
	input wire logic clk_in,
	output asf_instr_t instr_out,
	output logic [2:0] ev_out
);
	initial
	begin
		instr_out = '0;
		ev_out = 3'h0;
	end
	// Ev bits: 0 time-out, 1 watchdog clear, 2 halt
	task automatic step(input asf_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic dst, input logic [2:0] ev);
		@(posedge clk_in);
		instr_out <= '{(op != ASF_OP_NONE), op, a, b, 3'h0, dst};
		ev_out <= ev;
		@(posedge clk_in);
		instr_out <= '0;
		ev_out <= 3'h0;
		#1;
	endtask : step
endmodule : asf_core_model
`default_nettype wire

// ==== bench/asf_flags_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module asf_flags_monitor
	import asf_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire asf_instr_t INSTR_IN,
	input wire logic WDOG_TIMEOUT_IN,
	input wire logic WDOG_CLEAR_IN,
	input wire logic HALT_IN,
	input wire logic [7:0] FLAGS_OUT,
	input wire logic RESULT_VALID_OUT
);
	logic [8:0] add9, sub9;
	logic [4:0] add5, sub5;
	logic [2:0] add_f, sub_f;
	logic rot_c, ev_none, go;
	assign add9 = {1'b0, INSTR_IN.a} + {1'b0, INSTR_IN.b};
	assign sub9 = {1'b0, INSTR_IN.a} + {1'b0, ~INSTR_IN.b} + 9'h001;
	assign add5 = {1'b0, INSTR_IN.a[3:0]} + {1'b0, INSTR_IN.b[3:0]};
	assign sub5 = {1'b0, INSTR_IN.a[3:0]} + {1'b0, ~INSTR_IN.b[3:0]} + 5'h01;
	assign add_f = {add9[7:0] == 8'h00, add5[4], add9[8]};
	assign sub_f = {sub9[7:0] == 8'h00, sub5[4], sub9[8]};
	assign rot_c = (INSTR_IN.op == ASF_OP_ROTL) ? INSTR_IN.a[7] : INSTR_IN.a[0];
	assign ev_none = !(WDOG_TIMEOUT_IN || WDOG_CLEAR_IN || HALT_IN);
	assign go = INSTR_IN.valid;
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	property p_hi_zero;
		FLAGS_OUT[7:5] == 3'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero)
		else $error("upper flag bits set");
	property p_tout;
		WDOG_TIMEOUT_IN |=> !FLAGS_OUT[4];
	endproperty
	a_tout: assert property (p_tout)
		else $error("expiry flag kept after time-out");
	property p_halt;
		HALT_IN && !WDOG_CLEAR_IN && !WDOG_TIMEOUT_IN |=> FLAGS_OUT[4:3] == 2'b10;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt cause bits wrong");
	property p_cause;
		ev_none |=> $stable(FLAGS_OUT[4:3]);
	endproperty
	a_cause: assert property (p_cause)
		else $error("cause bits moved without event");
	property p_add;
		go && INSTR_IN.op == ASF_OP_ADD |=> FLAGS_OUT[2:0] == $past(add_f);
	endproperty
	a_add: assert property (p_add)
		else $error("add flags wrong");
	property p_sub;
		go && INSTR_IN.op == ASF_OP_SUB |=> FLAGS_OUT[2:0] == $past(sub_f);
	endproperty
	a_sub: assert property (p_sub)
		else $error("subtract flags wrong");
	property p_rot;
		go && INSTR_IN.op inside {ASF_OP_ROTL, ASF_OP_ROTR}
			|=> FLAGS_OUT[0] == $past(rot_c);
	endproperty
	a_rot: assert property (p_rot)
		else $error("rotate carry wrong");
	property p_done;
		go |=> RESULT_VALID_OUT;
	endproperty
	a_done: assert property (p_done)
		else $error("no result strobe");
endmodule : asf_flags_monitor
bind asf_flags asf_flags_monitor mon (
	.CORE_CLK_IN,
	.NRST_IN,
	.INSTR_IN,
	.WDOG_TIMEOUT_IN,
	.WDOG_CLEAR_IN,
	.HALT_IN,
	.FLAGS_OUT,
	.RESULT_VALID_OUT
);
`default_nettype wire

// ==== bench/test_asf_flags.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_asf_flags
	import asf_pkg::*;
;
	logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = '0, rdat, q;
	logic ack, rv, irq;
	logic [7:0] flags, res;
	logic [2:0] ev;
	asf_instr_t instr;
	int errors = 0, checks_done = 0;
	// ----
	// Row: op, a, b, dest, expected flags
	// ----
	logic [31:0] tab [16] = '{32'h10F0_101A, 32'h1FF0_111F, 32'h2050_301B,
		32'h2030_5018, 32'h8010_0019, 32'h77F0_0018, 32'h7800_0019,
		32'h3F00_F01D, 32'h4010_0019, 32'h6000_011D, 32'h9E2E_211A,
		32'h55A5_A01E, 32'hA000_001E, 32'hB000_001E, 32'hC000_001E,
		32'hD000_001E};
	logic [4:0] evt [3] = '{5'h05, 5'h12, 5'h0B};
	initial forever #50 clk = ~clk;
	asf_core_model core (.clk_in(clk), .instr_out(instr), .ev_out(ev));
	asf_flags dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .INSTR_IN(instr),
		.WDOG_TIMEOUT_IN(ev[0]), .WDOG_CLEAR_IN(ev[1]), .HALT_IN(ev[2]),
		.WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .FLAGS_OUT(flags), .RESULT_OUT(res),
		.RESULT_VALID_OUT(rv), .IRQ_OUT(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		r = rdat;
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic final_report;
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk(flags, 8'h18);
		wb(1'b0, ADDR_FLAGS, '0, q);
		chk(q, 32'h18);
		foreach (tab[i])
		begin
			core.step(asf_op_t'(tab[i][31:28]), tab[i][27:20], tab[i][19:12],
				tab[i][8], 3'h0);
			chk({rv, flags}, {1'b1, tab[i][7:0]});
		end
		foreach (evt[i])
		begin
			core.step(ASF_OP_NONE, 8'h00, 8'h00, 1'b0, evt[i][4:2]);
			chk(flags[4:3], evt[i][1:0]);
		end
		wb(1'b0, ADDR_IRQ_STATUS, '0, q);
		chk(q, 32'h0000_001F);
		chk(irq, 1'b0);
		wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002, q);
		@(posedge clk);
		#1;
		chk(irq, 1'b1);
		wb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0002, q);
		@(posedge clk);
		#1;
		chk(irq, 1'b0);
		wb(1'b0, ADDR_IRQ_STATUS, '0, q);
		chk(q, 32'h1D);
		wb(1'b0, 4'hC, '0, q);
		chk(q, '0);
		wb(1'b1, ADDR_FLAGS, '0, q);
		wb(1'b0, ADDR_FLAGS, '0, q);
		chk(q, 32'h1E);
		final_report();
	end
	// Run needs about 70 cycles
	initial
	begin
		repeat (2000) @(posedge clk);
		errors++;
		final_report();
	end
endmodule : test_asf_flags
`default_nettype wire
